// ---- hw/spiid_pkg.sv ----
package spiid_pkg;
	// Instruction codes
	localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OPC_RDSR   = 8'h05;
	localparam logic [7:0] OPC_IDWR   = 8'hB2;
	localparam logic [7:0] OPC_IDRD   = 8'hB3;
	// Page, word, ECC and frame layout
	localparam int PAGE_BYTES = 256;
	localparam int WORD_BYTES = 4;
	localparam int ECC_BITS   = 6;
	localparam int ADDR_BYTES = 3;
	localparam int A10_POS    = 10;
	localparam int FREEZE_BIT = 1;
	localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;
	// Status byte bit positions
	localparam int SR_BUSY = 0;
	localparam int SR_LATCH = 1;
	localparam int SR_BPLO = 2;
	localparam int SR_BPHI = 3;
	localparam int SR_SWD  = 7;
	// Timing
	localparam int CLK_NS       = 50;
	localparam int T_WC_US      = 5000;
	localparam int WC_CYCLES    = T_WC_US * 1000 / CLK_NS;
	localparam int SCK_HALF_NS  = 400;
	localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
	// Host register map (byte addresses) and control fields
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_TXD  = 8'h08;
	localparam logic [7:0] REG_RXD  = 8'h0C;
	localparam logic [7:0] REG_STAT = 8'h10;
	localparam int CTL_HASADDR = 8;
	localparam int CTL_LEN     = 9;
	localparam int CTL_LEN_W   = 3;
endpackage : spiid_pkg

// ---- hw/spiid_link_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface spiid_link_if;
	logic sck;
	logic cs_n;
	logic mosi;
	logic miso_d;
	logic miso_oe;
	logic miso;
	// Serial output line floats high when the device does not drive it
	assign miso = miso_oe ? miso_d : 1'h1;
	modport dev (input sck, input cs_n, input mosi, output miso_d, output miso_oe);
	modport host (output sck, output cs_n, output mosi, input miso);
endinterface : spiid_link_if
`default_nettype wire

// ---- hw/spiid_dev.sv ----
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module spiid_dev #(
	parameter int WC_CYCLES = spiid_pkg::WC_CYCLES
) (
	// Clock and reset
	input  wire logic           clk_i,
	input  wire logic           rst_i,
	// Serial link
	spiid_link_if.dev           link,
	// Nonvolatile status bits
	input  wire logic           block_protect_hi_i,
	input  wire logic           block_protect_lo_i,
	input  wire logic           status_write_disable_i,
	// Status
	output logic                programming_busy_flag_o,
	output logic                write_enable_latch_o,
	output logic                id_locked_o
);
	localparam int EB = spiid_pkg::ECC_BITS;
	localparam int NW = spiid_pkg::PAGE_BYTES / spiid_pkg::WORD_BYTES;
	localparam int WCW = $clog2(WC_CYCLES + 1);

	typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_WDATA, ST_RDID, ST_RDLOCK, ST_RDSR, ST_SKIP} spiid_dst_t;

	// Check bits are the XOR of the code positions of all set data bits
	function automatic logic [EB-1:0] ecc_chk(input logic [31:0] d);
		logic [EB-1:0] c;
		int            p;
		c = '0;
		p = 2;
		for (int i = 0; i < 32; i++) begin
			p = p + 1;
			if ((p & (p - 1)) == 0) p = p + 1;
			if (d[i]) c = c ^ EB'(p);
		end
		return c;
	endfunction : ecc_chk

	// A syndrome equal to a data bit's code position names that flipped data bit
	function automatic logic [31:0] ecc_fix(input logic [EB+31:0] w);
		logic [31:0]   d;
		logic [EB-1:0] s;
		int            p;
		d = w[31:0];
		s = w[EB+31:32] ^ ecc_chk(w[31:0]);
		p = 2;
		for (int i = 0; i < 32; i++) begin
			p = p + 1;
			if ((p & (p - 1)) == 0) p = p + 1;
			if (EB'(p) == s) d[i] = ~d[i];
		end
		return d;
	endfunction : ecc_fix

	localparam logic [EB+31:0] INIT_WORD = {ecc_chk(spiid_pkg::ERASED_WORD), spiid_pkg::ERASED_WORD};

	// Nonvolatile storage: not touched by reset
	logic [EB+31:0] mem_r [NW] = '{default: INIT_WORD};
	logic           lock_r = 1'h0;
	logic [7:0]     pend_r [spiid_pkg::PAGE_BYTES];

	logic [2:0]     sy1_r, sy2_r, prev_r, armed_r;
	spiid_dst_t     st_r, st_nxt;
	logic [2:0]     bit_r, bit_nxt, bidx_r, bidx_nxt;
	logic [7:0]     sh_r, sh_nxt, opc_r, opc_nxt, ptr_r, ptr_nxt, out_r, out_nxt, last_r, last_nxt;
	logic [23:0]    addr_r, addr_nxt;
	logic           frz_r, frz_nxt, kfrz_r, kfrz_nxt, got_r, got_nxt;
	logic           miso_r, miso_nxt, oe_r, oe_nxt, wel_r, wel_nxt, busy_r, busy_nxt;
	logic           walk_r, walk_nxt;
	logic [6:0]     widx_r, widx_nxt;
	logic [WCW-1:0] wc_r, wc_nxt;
	logic [255:0]   mask_r, mask_nxt;
	logic           pend_we, mem_we, lock_set;
	logic [7:0]     pend_wa, pend_wd;
	logic [EB+31:0] mem_wd;
	logic           sck_rise, sck_fall, cs_rise, cs_fall, bp_all, rd_st;

	function automatic logic [7:0] page_byte(input logic [7:0] a);
		logic [31:0] w;
		w = ecc_fix(mem_r[a[7:2]]);
		return w[{a[1:0], 3'h0} +: 8];
	endfunction : page_byte

	function automatic logic [7:0] stat_byte(input logic busy, input logic write_enable_latch);
		logic [7:0] s;
		s = 8'h00;
		s[spiid_pkg::SR_BUSY] = busy;
		s[spiid_pkg::SR_LATCH] = write_enable_latch;
		s[spiid_pkg::SR_BPLO] = block_protect_lo_i;
		s[spiid_pkg::SR_BPHI] = block_protect_hi_i;
		s[spiid_pkg::SR_SWD]  = status_write_disable_i;
		return s;
	endfunction : stat_byte

	// Pin synchronisers, bits are {sck, cs_n, mosi}
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// Idle levels (chip select high) so no false edge follows reset
			sy1_r   <= 3'h2;
			sy2_r   <= 3'h2;
			prev_r  <= 3'h2;
			armed_r <= 3'h0;
		end else begin
			sy1_r   <= {link.sck, link.cs_n, link.mosi};
			sy2_r   <= sy1_r;
			prev_r  <= sy2_r;
			armed_r <= armed_r | {1'h0, sy2_r[1], 1'h0};
		end
	end

	// Edges; a select only counts after chip select was seen high
	assign sck_rise = sy2_r[2] & ~prev_r[2];
	assign sck_fall = ~sy2_r[2] & prev_r[2];
	assign cs_fall  = armed_r[1] & prev_r[1] & ~sy2_r[1];
	assign cs_rise  = sy2_r[1] & ~prev_r[1];
	assign bp_all   = block_protect_hi_i & block_protect_lo_i;
	assign rd_st    = (st_r == ST_RDID) || (st_r == ST_RDLOCK) || (st_r == ST_RDSR);

	// Next values of the instruction decoder and programming sequencer
	always_comb begin
		logic [7:0]  b;
		logic [23:0] af;
		logic [31:0] w;
		b = {sh_r[6:0], sy2_r[0]};
		af = {addr_r[15:0], b};
		w = ecc_fix(mem_r[widx_r[5:0]]);
		st_nxt = st_r; bit_nxt = bit_r; bidx_nxt = bidx_r; sh_nxt = sh_r; opc_nxt = opc_r;
		ptr_nxt = ptr_r; out_nxt = out_r; last_nxt = last_r; addr_nxt = addr_r; frz_nxt = frz_r;
		kfrz_nxt = kfrz_r; got_nxt = got_r; miso_nxt = miso_r; oe_nxt = oe_r; wel_nxt = wel_r;
		busy_nxt = busy_r; walk_nxt = walk_r; widx_nxt = widx_r; wc_nxt = wc_r; mask_nxt = mask_r;
		pend_we = 1'h0; pend_wa = ptr_r; pend_wd = b; mem_we = 1'h0; lock_set = 1'h0;
		if (cs_fall) begin
			st_nxt = ST_HDR;
			bit_nxt = 3'h0;
			bidx_nxt = 3'h0;
			got_nxt = 1'h0;
			if (!busy_r) mask_nxt = '0;
		end else if (cs_rise) begin
			// Commit only on a byte boundary with every guard clear
			if (st_r == ST_WDATA && bit_r == 3'h0 && got_r && wel_r && !bp_all && !busy_r && !lock_r
				&& (!frz_r || last_r[spiid_pkg::FREEZE_BIT])) begin
				busy_nxt = 1'h1;
				wc_nxt = '0;
				kfrz_nxt = frz_r;
				walk_nxt = ~frz_r;
				widx_nxt = 7'h00;
			end
			if (st_r != ST_IDLE && opc_r == spiid_pkg::OPC_WRITE_ENABLE && bidx_r == 3'h1 && bit_r == 3'h0)
				wel_nxt = 1'h1;
			st_nxt = ST_IDLE;
			oe_nxt = 1'h0;
		end else if (st_r != ST_IDLE) begin
			if (sck_rise) begin
				sh_nxt = b;
				bit_nxt = bit_r + 3'h1;
				if (bit_r == 3'h7) begin
					bidx_nxt = (bidx_r == 3'h4) ? bidx_r : bidx_r + 3'h1;
					case (st_r)
						ST_HDR: begin
							if (bidx_r == 3'h0) begin
								opc_nxt = b;
								if (b == spiid_pkg::OPC_RDSR) begin
									st_nxt = ST_RDSR;
									out_nxt = stat_byte(busy_r, wel_r);
								end else if (b != spiid_pkg::OPC_IDWR && b != spiid_pkg::OPC_IDRD)
									st_nxt = ST_SKIP;
							end else begin
								addr_nxt = af;
								if (bidx_r == 3'(spiid_pkg::ADDR_BYTES)) begin
									frz_nxt = af[spiid_pkg::A10_POS];
									ptr_nxt = b;
									if (opc_r == spiid_pkg::OPC_IDWR)
										st_nxt = ST_WDATA;
									else if (busy_r)
										st_nxt = ST_SKIP;
									else if (af[spiid_pkg::A10_POS]) begin
										st_nxt = ST_RDLOCK;
										out_nxt = {7'h00, lock_r};
									end else begin
										st_nxt = ST_RDID;
										out_nxt = page_byte(b);
										ptr_nxt = b + 8'h01;
									end
								end
							end
						end
						ST_WDATA: begin
							got_nxt = 1'h1;
							last_nxt = b;
							ptr_nxt = ptr_r + 8'h01;
							if (!busy_r) begin
								pend_we = 1'h1;
								mask_nxt[ptr_r] = 1'h1;
							end
						end
						ST_RDID: begin
							out_nxt = page_byte(ptr_r);
							ptr_nxt = ptr_r + 8'h01;
						end
						ST_RDLOCK: out_nxt = {7'h00, lock_r};
						ST_RDSR: out_nxt = stat_byte(busy_r, wel_r);
						default: ;
					endcase
				end
			end
			if (sck_fall && rd_st) begin
				miso_nxt = out_r[7];
				out_nxt = {out_r[6:0], 1'h0};
				oe_nxt = 1'h1;
			end
		end
		// Word merge: every touched word is rewritten whole with new check bits
		for (int i = 0; i < spiid_pkg::WORD_BYTES; i++) begin
			if (mask_r[{widx_r[5:0], 2'(i)}]) w[i*8 +: 8] = pend_r[{widx_r[5:0], 2'(i)}];
		end
		mem_wd = {ecc_chk(w), w};
		if (walk_r) begin
			mem_we = |mask_r[{widx_r[5:0], 2'h0} +: 4];
			widx_nxt = widx_r + 7'h01;
			if (widx_r == 7'(NW - 1)) walk_nxt = 1'h0;
		end
		if (busy_r) begin
			wc_nxt = wc_r + WCW'(1);
			if (wc_r == WCW'(WC_CYCLES - 1)) begin
				busy_nxt = 1'h0;
				wel_nxt = 1'h0;
				lock_set = kfrz_r;
			end
		end
	end

	// Register the decoder and sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= ST_IDLE;
			wel_r <= 1'h0;
			busy_r <= 1'h0;
			bit_r <= 3'h0; bidx_r <= 3'h0; sh_r <= 8'h00; opc_r <= 8'h00; ptr_r <= 8'h00;
			out_r <= 8'h00; last_r <= 8'h00; addr_r <= 24'h000000; frz_r <= 1'h0; kfrz_r <= 1'h0;
			got_r <= 1'h0; miso_r <= 1'h0; oe_r <= 1'h0; walk_r <= 1'h0; widx_r <= 7'h00;
			wc_r <= '0; mask_r <= '0;
		end else begin
			st_r <= st_nxt; wel_r <= wel_nxt; busy_r <= busy_nxt;
			bit_r <= bit_nxt; bidx_r <= bidx_nxt; sh_r <= sh_nxt; opc_r <= opc_nxt; ptr_r <= ptr_nxt;
			out_r <= out_nxt; last_r <= last_nxt; addr_r <= addr_nxt; frz_r <= frz_nxt; kfrz_r <= kfrz_nxt;
			got_r <= got_nxt; miso_r <= miso_nxt; oe_r <= oe_nxt; walk_r <= walk_nxt; widx_r <= widx_nxt;
			wc_r <= wc_nxt; mask_r <= mask_nxt;
		end
	end

	// Page buffer, array and freeze bit
	always_ff @(posedge clk_i) begin
		if (pend_we) pend_r[pend_wa] <= pend_wd;
		if (mem_we) mem_r[widx_r[5:0]] <= mem_wd;
		if (lock_set) lock_r <= 1'h1;
	end

	assign link.miso_d = miso_r;
	assign link.miso_oe = oe_r;
	assign programming_busy_flag_o = busy_r;
	assign write_enable_latch_o = wel_r;
	assign id_locked_o = lock_r;
endmodule : spiid_dev
`default_nettype wire

// ---- hw/spiid_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module spiid_host #(
	parameter int HALF = spiid_pkg::SCK_HALF_CYC
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Serial link
	spiid_link_if.host       link
);
	typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_TAIL, H_GAP} spiid_hst_t;

	function automatic logic [31:0] lanes(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
		return r;
	endfunction : lanes

	spiid_hst_t  st_r, st_nxt;
	logic [63:0] sh_r, sh_nxt;
	logic [6:0]  nb_r, nb_nxt;
	logic [7:0]  div_r, div_nxt;
	logic [31:0] addr_r, addr_nxt, txd_r, txd_nxt, rxd_r, rxd_nxt, dat_r, dat_nxt;
	logic        ack_r, ack_nxt, sck_r, sck_nxt, cs_n_r, cs_n_nxt, mosi_r, mosi_nxt;
	logic        m1_r, m2_r, tick;
	logic [2:0]  len;

	assign tick = (div_r == 8'(HALF - 1));
	assign len = wb_dat_i[spiid_pkg::CTL_LEN +: spiid_pkg::CTL_LEN_W];

	// Bus slave, frame sequencer and sck divider
	always_comb begin
		logic [31:0] ln;
		ln = lanes(addr_r, wb_dat_i, wb_sel_i);
		st_nxt = st_r; sh_nxt = sh_r; nb_nxt = nb_r; addr_nxt = addr_r; txd_nxt = txd_r;
		rxd_nxt = rxd_r; dat_nxt = dat_r; sck_nxt = sck_r; cs_n_nxt = cs_n_r; mosi_nxt = mosi_r;
		div_nxt = (st_r == H_IDLE || tick) ? 8'h00 : div_r + 8'h01;
		ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
		if (ack_nxt) begin
			dat_nxt = 32'h00000000;
			if (wb_adr_i == spiid_pkg::REG_ADDR)
				dat_nxt = addr_r;
			else if (wb_adr_i == spiid_pkg::REG_TXD)
				dat_nxt = txd_r;
			else if (wb_adr_i == spiid_pkg::REG_RXD)
				dat_nxt = rxd_r;
			else if (wb_adr_i == spiid_pkg::REG_STAT)
				dat_nxt = {31'h00000000, st_r != H_IDLE};
			if (wb_we_i) begin
				if (wb_adr_i == spiid_pkg::REG_ADDR)
					addr_nxt = {8'h00, ln[23:0]};
				else if (wb_adr_i == spiid_pkg::REG_TXD)
					txd_nxt = lanes(txd_r, wb_dat_i, wb_sel_i);
				else if (wb_adr_i == spiid_pkg::REG_CTRL && wb_sel_i[0] && st_r == H_IDLE) begin
					// Start a frame: opcode, optional address, then data bytes
					if (wb_dat_i[spiid_pkg::CTL_HASADDR]) begin
						sh_nxt = {wb_dat_i[7:0], addr_r[23:0], txd_r};
						nb_nxt = 7'(32 + 8 * int'(len));
					end else begin
						sh_nxt = {wb_dat_i[7:0], txd_r, 24'h000000};
						nb_nxt = 7'(8 + 8 * int'(len));
					end
					cs_n_nxt = 1'h0;
					mosi_nxt = wb_dat_i[7];
					st_nxt = H_LOW;
				end
			end
		end
		if (tick) begin
			case (st_r)
				H_LOW: begin
					sck_nxt = 1'h1;
					rxd_nxt = {rxd_r[30:0], m2_r};
				end
				H_HIGH: begin
					sck_nxt = 1'h0;
					sh_nxt = {sh_r[62:0], 1'h0};
					nb_nxt = nb_r - 7'h01;
					mosi_nxt = sh_r[62];
				end
				H_TAIL: cs_n_nxt = 1'h1;
				default: ;
			endcase
			case (st_r)
				H_LOW: st_nxt = H_HIGH;
				H_HIGH: st_nxt = (nb_r == 7'h01) ? H_TAIL : H_LOW;
				H_TAIL: st_nxt = H_GAP;
				H_GAP: st_nxt = H_IDLE;
				default: ;
			endcase
		end
	end

	// Register bus, link and sequencer state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= H_IDLE; sh_r <= 64'h0; nb_r <= 7'h00; div_r <= 8'h00; addr_r <= 32'h0;
			txd_r <= 32'h0; rxd_r <= 32'h0; dat_r <= 32'h0; ack_r <= 1'h0; sck_r <= 1'h0;
			cs_n_r <= 1'h1; mosi_r <= 1'h0; m1_r <= 1'h0; m2_r <= 1'h0;
		end else begin
			st_r <= st_nxt; sh_r <= sh_nxt; nb_r <= nb_nxt; div_r <= div_nxt; addr_r <= addr_nxt;
			txd_r <= txd_nxt; rxd_r <= rxd_nxt; dat_r <= dat_nxt; ack_r <= ack_nxt; sck_r <= sck_nxt;
			cs_n_r <= cs_n_nxt; mosi_r <= mosi_nxt; m1_r <= link.miso; m2_r <= m1_r;
		end
	end

	assign wb_dat_o = dat_r;
	assign wb_ack_o = ack_r;
	assign link.sck = sck_r;
	assign link.cs_n = cs_n_r;
	assign link.mosi = mosi_r;
endmodule : spiid_host
`default_nettype wire

// ---- testbench/spiid_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module spiid_props #(
	parameter int WC = 200
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Link
	input wire logic sck,
	input wire logic cs_n,
	input wire logic miso_oe,
	// Device status
	input wire logic programming_busy_flag_o,
	input wire logic write_enable_latch_o,
	input wire logic id_locked_o,
	// Bus handshake
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o
);
	logic [31:0] run_r;
	logic [31:0] run_nxt;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Length of the current programming run
	always_comb begin
		run_nxt = programming_busy_flag_o ? run_r + 32'h1 : 32'h0;
	end
	always_ff @(posedge clk_i) begin
		run_r <= rst_i ? 32'h0 : run_nxt;
	end
	sequence busy_run_s;
		programming_busy_flag_o [*8];
	endsequence
	// Bus answer and serial framing
	ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	clk_low_a: assert property ($rose(cs_n) |-> !sck) else $error("clock high at deselect");
	oe_release_a: assert property (cs_n [*8] |-> !miso_oe) else $error("output driven when idle");
	// Programming cycle
	busy_start_a: assert property ($rose(programming_busy_flag_o) |-> cs_n ##1 busy_run_s)
		else $error("busy start wrong");
	busy_len_a: assert property ($fell(programming_busy_flag_o) |-> run_r >= WC - 1 && run_r <= WC + 1)
		else $error("busy length wrong");
	wel_clear_a: assert property ($fell(programming_busy_flag_o) |-> ##[0:1] !write_enable_latch_o)
		else $error("latch kept");
	wel_set_a: assert property ($rose(write_enable_latch_o) |-> cs_n) else $error("latch set in frame");
	lock_keep_a: assert property (id_locked_o |=> id_locked_o) else $error("lock lost");
	lock_set_a: assert property ($rose(id_locked_o) |-> $past(programming_busy_flag_o))
		else $error("lock without cycle");
endmodule : spiid_props
`default_nettype wire

// ---- testbench/tb_spi_eeprom_id_page_lock.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_spi_eeprom_id_page_lock;
	localparam int WC = 2000;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [31:0] rdat;
	logic        ack;
	logic        bph = 1'b0;
	logic        bpl = 1'b0;
	logic        swd = 1'b0;
	logic        busy, write_enable_latch, lck, busy2, wel2;
	logic [7:0]  mon = 8'h00;
	int          error_cnt = 0;
	int          checks_done = 0;
	spiid_link_if l1();
	spiid_link_if l2();
	always #25 clk_i = ~clk_i;
	// Two ends face each other; a second device is bit-banged
	spiid_host spiid_host_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .link(l1.host));
	spiid_dev #(.WC_CYCLES(WC)) spiid_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .link(l1.dev),
		.block_protect_hi_i(bph), .block_protect_lo_i(bpl), .status_write_disable_i(swd),
		.programming_busy_flag_o(busy), .write_enable_latch_o(write_enable_latch), .id_locked_o(lck));
	spiid_dev #(.WC_CYCLES(WC)) spiid_dev_inst2 (.clk_i(clk_i), .rst_i(rst_i), .link(l2.dev),
		.block_protect_hi_i(1'b0), .block_protect_lo_i(1'b0), .status_write_disable_i(1'b0),
		.programming_busy_flag_o(busy2), .write_enable_latch_o(wel2), .id_locked_o());
	spiid_props #(.WC(WC)) spiid_props_inst (.clk_i(clk_i), .rst_i(rst_i), .sck(l1.sck), .cs_n(l1.cs_n),
		.miso_oe(l1.miso_oe), .programming_busy_flag_o(busy), .write_enable_latch_o(write_enable_latch), .id_locked_o(lck),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack));
	// Last eight bits the host shifted out
	always @(posedge l1.sck) begin
		if (!l1.cs_n) begin
			mon <= {mon[6:0], l1.mosi};
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		@(posedge clk_i);
		while (ack !== 1'b1 && n < 50) begin
			n++;
			@(posedge clk_i);
		end
		if (ack !== 1'b1) begin
			error_cnt++;
			$display("BAD t=%0t ack timeout got=%h exp=%h", $time, ack, 1'b1);
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task automatic frame(input logic [7:0] op, input logic ha, input logic [2:0] len, input logic [23:0] a,
		input logic [31:0] tx);
		logic [31:0] q;
		int n;
		n = 0;
		wb(1'b1, spiid_pkg::REG_ADDR, {8'h00, a}, q);
		wb(1'b1, spiid_pkg::REG_TXD, tx, q);
		wb(1'b1, spiid_pkg::REG_CTRL, {20'h0, len, ha, op}, q);
		q = 32'h1;
		while (q[0] !== 1'b0 && n < 500) begin
			n++;
			wb(1'b0, spiid_pkg::REG_STAT, 32'h0, q);
		end
		if (q[0] !== 1'b0) begin
			error_cnt++;
			$display("BAD t=%0t frame timeout got=%h exp=%h", $time, q[0], 1'b0);
		end
	endtask : frame
	task automatic set_latch();
		frame(spiid_pkg::OPC_WRITE_ENABLE, 1'b0, 3'h0, 24'h0, 32'h0);
	endtask : set_latch
	task automatic wr(input logic [23:0] a, input logic [2:0] len, input logic [31:0] d);
		frame(spiid_pkg::OPC_IDWR, 1'b1, len, a, d);
	endtask : wr
	task automatic rd(input logic [23:0] a, input logic [2:0] len, output logic [31:0] q);
		frame(spiid_pkg::OPC_IDRD, 1'b1, len, a, 32'h0);
		wb(1'b0, spiid_pkg::REG_RXD, 32'h0, q);
	endtask : rd
	task automatic rdsr(output logic [31:0] q);
		frame(spiid_pkg::OPC_RDSR, 1'b0, 3'h1, 24'h0, 32'h0);
		wb(1'b0, spiid_pkg::REG_RXD, 32'h0, q);
	endtask : rdsr
	// Wait out a programming cycle
	task automatic idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 3000) begin
			n++;
			@(posedge clk_i);
		end
		if (busy !== 1'b0) begin
			error_cnt++;
			$display("BAD t=%0t busy timeout got=%h exp=%h", $time, busy, 1'b0);
		end
	endtask : idle
	// Serial frame of n bits on the second link, 400 ns clock period
	task automatic bb(input logic [47:0] v, input int n);
		l2.cs_n <= 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			l2.mosi <= v[i];
			repeat (4) @(posedge clk_i);
			l2.sck <= 1'b1;
			repeat (4) @(posedge clk_i);
			l2.sck <= 1'b0;
		end
		repeat (4) @(posedge clk_i);
		l2.cs_n <= 1'b1;
		repeat (16) @(posedge clk_i);
	endtask : bb
	task automatic t_power();
		logic [31:0] q;
		chk({29'h0, busy, write_enable_latch, lck}, 32'h0);
		rdsr(q);
		chk({24'h0, q[7:0]}, 32'h0);
		rd(24'h000000, 3'h4, q);
		chk(q, 32'hFFFFFFFF);
		$display("test power done");
	endtask : t_power
	task automatic t_write();
		logic [31:0] q;
		wr(24'h000010, 3'h4, 32'h11223344);
		chk({31'h0, busy}, 32'h0);
		set_latch();
		chk({24'h0, mon}, {24'h0, spiid_pkg::OPC_WRITE_ENABLE});
		chk({31'h0, write_enable_latch}, 32'h1);
		wr(24'hFFFB10, 3'h4, 32'h11223344);
		chk({31'h0, busy}, 32'h1);
		idle();
		chk({31'h0, write_enable_latch}, 32'h0);
		set_latch();
		wr(24'h000012, 3'h1, 32'h55000000);
		wr(24'h000020, 3'h1, 32'hAA000000);
		idle();
		rd(24'h000010, 3'h4, q);
		chk(q, 32'h11225544);
		rd(24'h000020, 3'h4, q);
		chk(q, 32'hFFFFFFFF);
		$display("test write done");
	endtask : t_write
	task automatic t_protect();
		logic [31:0] q;
		swd <= 1'b1;
		bph <= 1'b1;
		bpl <= 1'b1;
		set_latch();
		rdsr(q);
		chk({24'h0, q[7:0]}, 32'h0000008E);
		wr(24'h000030, 3'h1, 32'h77000000);
		chk({31'h0, busy}, 32'h0);
		wr(24'h000400, 3'h1, 32'h02000000);
		chk({30'h0, busy, lck}, 32'h0);
		swd <= 1'b0;
		bph <= 1'b0;
		bpl <= 1'b0;
		$display("test protect done");
	endtask : t_protect
	task automatic t_lock();
		logic [31:0] q;
		rd(24'hFFFFFF, 3'h2, q);
		chk({16'h0, q[15:0]}, 32'h0);
		set_latch();
		wr(24'h000400, 3'h1, 32'hFD000000);
		chk({30'h0, busy, lck}, 32'h0);
		set_latch();
		wr(24'hFFFFFF, 3'h1, 32'h02000000);
		chk({31'h0, busy}, 32'h1);
		idle();
		chk({31'h0, lck}, 32'h1);
		rd(24'h000400, 3'h3, q);
		chk({8'h0, q[23:0]}, 32'h00010101);
		set_latch();
		wr(24'h000010, 3'h4, 32'h0);
		chk({31'h0, busy}, 32'h0);
		wr(24'h000400, 3'h1, 32'h02000000);
		chk({31'h0, busy}, 32'h0);
		rd(24'h000010, 3'h4, q);
		chk(q, 32'h11225544);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({30'h0, write_enable_latch, lck}, 32'h1);
		$display("test lock done");
	endtask : t_lock
	task automatic t_edge();
		bb(48'h6, 8);
		chk({31'h0, wel2}, 32'h1);
		bb({7'h0, 8'hB2, 24'h000010, 8'h5A, 1'b0}, 41);
		chk({31'h0, busy2}, 32'h0);
		bb(48'h6, 8);
		bb({8'h0, 8'hB2, 24'h000010, 8'h5A}, 40);
		chk({31'h0, busy2}, 32'h1);
		$display("test edge done");
	endtask : t_edge
	task automatic summarize();
		$display("checks=%0d errors=%0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : summarize
	// Main sequence
	initial begin
		l2.sck = 1'b0;
		l2.cs_n = 1'b1;
		l2.mosi = 1'b0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_power();
		t_write();
		t_protect();
		t_lock();
		t_edge();
		summarize();
	end
	// Watchdog
	initial begin
		repeat (80000) @(posedge clk_i);
		error_cnt++;
		$display("BAD t=%0t watchdog got=%h exp=%h", $time, 1'b1, 1'b0);
		summarize();
	end
endmodule : tb_spi_eeprom_id_page_lock
`default_nettype wire
